// ---- tb_mcu_interrupt_wake_controller.sv ----
`timescale 1ns/1ns
`default_nettype none

module tb_mcu_interrupt_wake_controller;
  import wkc_pkg::*;

  logic clk_i, rst_i, wb_ack_o, breakpoint_request, dmode, hreq, reloc, ack, reti, lp;
  logic irq_req_o, osc_o, t0run, t1run, men, took;
  logic [31:0] wb_dat_o;
  logic [15:0] irq_vector_o, tvec;
  logic [7:0] hid, cid, gpio, route, rise, fall;
  wkc_wb_req_t wreq;
  wkc_src_t src;
  int miscompares, samples_checked;
  logic [7:0] ix [7] = '{WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, WKC_IDX_EXTENDED_IRQ_FLAGS, WKC_IDX_WAKE_SOURCE_MASK, WKC_IDX_IE,
    WKC_IDX_IP, WKC_IDX_IRQ_ENABLE_EXTENDED, WKC_IDX_IRQ_PRIORITY_EXTENDED};
  logic [7:0] rv [7] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  wkc_irq_wake dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wreq), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .src_i(src), .bkp_match_i(breakpoint_request), .i2cs_debug_mode_i(dmode),
    .host_dbg_req_i(hreq), .host_dbg_id_i(hid), .dbg_id_cfg_i(cid), .gpio_i(gpio),
    .pin_route_i(route), .pin_rise_en_i(rise), .pin_fall_en_i(fall),
    .vector_relocate_select_i(reloc), .irq_ack_i(ack), .reti_i(reti),
    .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o), .low_power_i(lp),
    .osc_restart_o(osc_o), .timer0_run_o(t0run), .timer1_run_o(t1run));

  wkc_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .en_i(men), .irq_req_i(irq_req_o),
    .irq_vector_i(irq_vector_o), .irq_ack_o(ack), .took_o(took), .took_vec_o(tvec));

  // Free running clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wreq <= '{1'b1, 1'b1, we, {a, 2'b00}, 4'hF, {24'h0, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wreq.cyc <= 1'b0;
    wreq.stb <= 1'b0;
    chk("wb_lat", 16'h2, 16'(n));
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk("reg", {8'h00, e}, {8'h00, q});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Next vector taken by the core, all ones if none
  task automatic wt(output logic [15:0] v);
    v = 16'hFFFF;
    for (int n = 0; n < 16 && v === 16'hFFFF; n++) begin
      @(posedge clk_i);
      if (took === 1'b1)
        v = tvec;
    end
  endtask

  task automatic rt(input int k);
    repeat (k) begin
      @(posedge clk_i);
      reti <= 1'b1;
      @(posedge clk_i);
      reti <= 1'b0;
    end
  endtask

  // Reference arbiter: high level first, ecc then lowest vector
  function automatic logic [15:0] exp_vec(logic [15:0] p, logic [7:0] r [4], logic rl);
    logic [14:0] en;
    logic [14:0] pr;
    logic [15:0] v;
    en = {r[2], r[0][6:0]};
    pr = {r[3], r[1][6:0]};
    v = 16'hFFFF;
    for (int l = 1; l >= 0 && r[0][7] && v === 16'hFFFF; l--) begin
      for (int k = 14; k >= 0; k--)
        if (p[k] && en[k] && pr[k] == l)
          v = 16'(k * 8 + 3);
      if (l == 0 && p[15])
        v = WKC_VEC_ECC;
    end
    if (v !== 16'hFFFF && rl)
      v[15:12] = WKC_PAGE_NIBBLE;
    return v;
  endfunction

  // Main sequence
  initial begin
    logic [15:0] v, lv;
    logic [7:0] d;
    logic [7:0] r [4];
    miscompares = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    wreq = '0;
    src = '0;
    {breakpoint_request, dmode, hreq, reloc, reti, lp} = '0;
    {hid, cid, gpio, route, rise, fall} = '0;
    men = 1'b1;
    void'($urandom(32'hfdd5));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rc(ix[i], rv[i]);
    rc(8'h90, 8'h00);
    for (int i = 2; i < 7; i++) begin
      d = 8'($urandom);
      wr(ix[i], d);
      rc(ix[i], (i == 4) ? (d & 8'h7F) : d);
    end
    wr(8'h90, 8'hFF);
    rc(8'h90, 8'h00);
    wr(WKC_IDX_IE, 8'h00);
    // Mirrored flags and the sticky master flag
    lv = 16'($urandom);
    src.ext_flags <= lv[5:0];
    wr(WKC_IDX_EXTENDED_IRQ_FLAGS, 8'hFF);
    rc(WKC_IDX_EXTENDED_IRQ_FLAGS, {lv[5:3], 1'b0, lv[2:0], 1'b0});
    @(posedge clk_i);
    src.i2cm_evt <= 1'b1;
    @(posedge clk_i);
    src.i2cm_evt <= 1'b0;
    rc(WKC_IDX_EXTENDED_IRQ_FLAGS, {lv[5:3], 1'b0, lv[2:0], 1'b1});
    wr(WKC_IDX_EXTENDED_IRQ_FLAGS, 8'h00);
    rc(WKC_IDX_EXTENDED_IRQ_FLAGS, {lv[5:3], 1'b0, lv[2:0], 1'b0});
    src.ext_flags <= 6'h00;
    wr(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'hFF);
    rc(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h50);
    chk("run", 16'h3, {14'h0, t1run, t0run});
    // Timer overflow vectoring and auto clear
    wr(WKC_IDX_IE, 8'h82);
    @(posedge clk_i);
    src.timer0_ovf <= 1'b1;
    @(posedge clk_i);
    src.timer0_ovf <= 1'b0;
    wt(v);
    chk("vec", 16'h000B, v);
    rc(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h50);
    rt(1);
    men <= 1'b0;
    reloc <= 1'b1;
    wr(WKC_IDX_IE, 8'h88);
    src.timer1_ovf <= 1'b1;
    @(posedge clk_i);
    src.timer1_ovf <= 1'b0;
    rc(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'hD0);
    wr(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h00);
    rc(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h80);
    men <= 1'b1;
    wt(v);
    chk("vec", 16'h701B, v);
    rc(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h00);
    rt(1);
    // Random enables, priorities and level requests
    for (int i = 0; i < 14; i++) begin
      for (int j = 0; j < 4; j++) begin
        r[j] = 8'($urandom);
        wr(ix[j + 3], r[j]);
      end
      reloc <= 1'($urandom);
      lv = 16'($urandom) & 16'hFF70;
      src.uart0 <= lv[4];
      src.timer2 <= lv[5];
      src.uart2 <= lv[6];
      src.watchdog <= lv[11];
      src.ecc <= lv[15];
      src.ext_flags <= {lv[14:12], lv[10:8]};
      @(posedge clk_i);
      wt(v);
      chk("vec", exp_vec(lv, r, reloc), v);
      src <= '0;
      rt(3);
    end
    // Low-level service preempted by a high-level request, which then blocks a low request
    reloc <= 1'b0;
    wr(WKC_IDX_IP, 8'h40);
    wr(WKC_IDX_IE, 8'hF0);
    src.uart0 <= 1'b1;
    wt(v);
    chk("vec", 16'h0023, v);
    src.uart2 <= 1'b1;
    wt(v);
    chk("vec", 16'h0033, v);
    src.timer2 <= 1'b1;
    wt(v);
    chk("vec", 16'hFFFF, v);
    src <= '0;
    rt(2);
    // Debug and breakpoint requests
    wr(WKC_IDX_IE, 8'h00);
    reloc <= 1'b0;
    cid <= 8'($urandom);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      dmode <= (i != 0);
      hid <= (i == 1) ? ~cid : cid;
      hreq <= 1'b1;
      breakpoint_request <= (i == 2);
      @(posedge clk_i);
      hreq <= 1'b0;
      breakpoint_request <= 1'b0;
      wt(v);
      chk("vec", (i == 2) ? WKC_VEC_DBG : 16'hFFFF, v);
    end
    rt(1);
    wt(v);
    chk("vec", WKC_VEC_BKP, v);
    rt(1);
    reloc <= 1'b1;
    breakpoint_request <= 1'b1;
    @(posedge clk_i);
    breakpoint_request <= 1'b0;
    wt(v);
    chk("vec", {WKC_PAGE_NIBBLE, WKC_VEC_BKP}, v);
    rt(1);
    // Wake from low power on masked edges
    wr(WKC_IDX_WAKE_SOURCE_MASK, 8'hFB);
    lp <= 1'b1;
    repeat (2) @(posedge clk_i);
    src.ext_flags <= 6'h01;
    repeat (6) @(posedge clk_i);
    chk("osc", 16'h0, {15'h0, osc_o});
    wr(WKC_IDX_WAKE_SOURCE_MASK, 8'h04);
    repeat (6) @(posedge clk_i);
    chk("osc", 16'h0, {15'h0, osc_o});
    src.ext_flags <= 6'h00;
    repeat (2) @(posedge clk_i);
    src.ext_flags <= 6'h01;
    repeat (4) @(posedge clk_i);
    chk("osc", 16'h1, {15'h0, osc_o});
    chk("irq", 16'h0, {15'h0, irq_req_o});
    lp <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("osc", 16'h0, {15'h0, osc_o});
    src.ext_flags <= 6'h00;
    wr(WKC_IDX_WAKE_SOURCE_MASK, 8'h01);
    rise <= 8'h08;
    lp <= 1'b1;
    repeat (2) @(posedge clk_i);
    gpio <= 8'h08;
    repeat (8) @(posedge clk_i);
    chk("osc", 16'h1, {15'h0, osc_o});
    lp <= 1'b0;
    rc(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h02);
    wr(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h00);
    rc(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h00);
    route <= 8'h08;
    fall <= 8'h08;
    gpio <= 8'h00;
    repeat (8) @(posedge clk_i);
    rc(WKC_IDX_TIMER_RUN_AND_PIN_FLAGS, 8'h08);
    end_of_test;
  end

  // Hang guard
  initial begin
    #80000;
    miscompares++;
    end_of_test;
  end
endmodule // tb_mcu_interrupt_wake_controller

`default_nettype wire

// ---- wkc_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module wkc_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Vector request from the controller
  input wire logic en_i,
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vector_i,
  output logic irq_ack_o,
  // Report of each vector taken
  output logic took_o,
  output logic [15:0] took_vec_o
);
  import wkc_pkg::*;

  // Acks a request one cycle after it shows; en_i low stalls the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ack_o <= 1'b0;
      took_o <= 1'b0;
      took_vec_o <= 16'h0000;
    end else begin
      irq_ack_o <= en_i && irq_req_i && !irq_ack_o;
      took_o <= irq_ack_o && irq_req_i;
      took_vec_o <= irq_vector_i;
    end
  end
endmodule // wkc_cpu_model

`default_nettype wire

// ---- wkc_irq_wake.sv ----
// Operation
// - Relocated vectors sit in top 4KB page
// - Debug above breakpoint above all peripherals
// - Debug raised on debug mode and ID match
// - Debug and breakpoint ignore all enable bits
// - Main enable register; global and own bit
// - Extended enable register bit layout
// - One priority bit per source, 1 high
// - Main priority register bit layout
// - Extended priority mirrors extended enable layout
// - Mirrored extended flag bits ignore writes
// - I2C master flag sticky, software clears
// - Extended flags mirror peripheral flags directly
// - Wake mask register, reset all ones
// - Enabled wake restarts oscillator and clock
// - Wake detection is edge based always
// - Wake path independent of interrupt enables
// - Only unclocked sources may wake
// - GPIO edges feed pin groups and wake
// - Timer overflow flags cleared on vectoring
// - Timer control run bits and pin flags
// - Requests sampled each clock, best vectored
// - Software writes only clear flags
// - High before low, then natural order
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none

module wkc_irq_wake (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire wkc_pkg::wkc_wb_req_t wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Peripheral sources
  input wire wkc_pkg::wkc_src_t src_i,
  input wire logic bkp_match_i,
  // Debug port request
  input wire logic i2cs_debug_mode_i,
  input wire logic host_dbg_req_i,
  input wire logic [wkc_pkg::WKC_DBG_ID_W-1:0] host_dbg_id_i,
  input wire logic [wkc_pkg::WKC_DBG_ID_W-1:0] dbg_id_cfg_i,
  // GPIO pins and routing
  input wire logic [wkc_pkg::WKC_GPIO_N-1:0] gpio_i,
  input wire logic [wkc_pkg::WKC_GPIO_N-1:0] pin_route_i,
  input wire logic [wkc_pkg::WKC_GPIO_N-1:0] pin_rise_en_i,
  input wire logic [wkc_pkg::WKC_GPIO_N-1:0] pin_fall_en_i,
  // CPU vectoring
  input wire logic vector_relocate_select_i,
  input wire logic irq_ack_i,
  input wire logic reti_i,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o,
  // Low power control
  input wire logic low_power_i,
  output logic osc_restart_o,
  // Timer run enables
  output logic timer0_run_o,
  output logic timer1_run_o
);
  import wkc_pkg::*;

  wkc_state_t st;
  wkc_state_t nx;
  logic [15:0] req;
  logic [15:0] en;
  logic [15:0] hi;
  logic [15:0] act;
  logic [4:0] hi_pick;
  logic [4:0] lo_pick;
  logic [WKC_GPIO_N-1:0] rise;
  logic [WKC_GPIO_N-1:0] fall;
  logic [WKC_GPIO_N-1:0] pin_evt;
  logic [1:0] grp_evt;
  logic [7:0] wake_hit;
  logic bus_go;
  logic bus_wr;
  logic [7:0] bidx;
  logic [7:0] wd;
  logic dbg_hit;

  // Lowest set index, with found flag in the top bit
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Vector address of a peripheral slot
  function automatic logic [15:0] slot_vec(input logic reloc, input logic [3:0] slot);
    logic [11:0] off;
    off = (slot == 4'h0) ? WKC_VEC_ECC : {5'h00, 4'(slot - 4'h1), WKC_VEC_LOW3};
    return {reloc ? WKC_PAGE_NIBBLE : 4'h0, off};
  endfunction

  // Request, enable and priority per natural slot
  always_comb begin
    req = {src_i.ext_flags[5:3], src_i.watchdog, src_i.ext_flags[2:0], st.i2cm_flag,
           src_i.uart2, src_i.timer2, src_i.uart0, st.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TF1],
           st.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_PG1], st.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TF0], st.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_PG0], src_i.ecc};
    en = {st.irq_enable_extended, st.ie[6:0], 1'b1};
    hi = {st.irq_priority_extended, st.ip[6:0], 1'b0};
    act = req & en & {16{st.ie[WKC_IE_GLOBAL]}};
    hi_pick = first_set(act & hi);
    lo_pick = first_set(act & ~hi);
  end

  // GPIO edge detection and group routing
  always_comb begin
    rise = st.gpio_s2 & ~st.gpio_prev;
    fall = ~st.gpio_s2 & st.gpio_prev;
    pin_evt = (rise & pin_rise_en_i) | (fall & pin_fall_en_i);
    grp_evt[0] = |(pin_evt & ~pin_route_i);
    grp_evt[1] = |(pin_evt & pin_route_i);
    // Edge of each unclocked source, masked; enables play no part
    wake_hit = {src_i.ext_flags & ~st.ext_prev, grp_evt} & st.wake_source_mask;
  end

  // Bus decode
  always_comb begin
    bus_go = wb_req_i.cyc && wb_req_i.stb && !st.bus_ack;
    bus_wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && st.bus_ack && wb_req_i.sel[0];
    bidx = wb_req_i.adr[WKC_ADR_W-1:2];
    wd = wb_req_i.dat[7:0];
    dbg_hit = i2cs_debug_mode_i && host_dbg_req_i && (host_dbg_id_i == dbg_id_cfg_i);
  end

  // Next state
  always_comb begin
    nx = st;
    // Pin synchronisers and edge history
    nx.gpio_s1 = gpio_i;
    nx.gpio_s2 = st.gpio_s1;
    nx.gpio_prev = st.gpio_s2;
    nx.ext_prev = src_i.ext_flags;

    // Register writes, taken at the acknowledged edge
    nx.bus_ack = bus_go;
    if (bus_wr) begin
      case (bidx)
        WKC_IDX_TIMER_RUN_AND_PIN_FLAGS: begin
          nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TR1] = wd[WKC_TIMER_RUN_AND_PIN_FLAGS_TR1];
          nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TR0] = wd[WKC_TIMER_RUN_AND_PIN_FLAGS_TR0];
          nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_PG1] = st.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_PG1] & wd[WKC_TIMER_RUN_AND_PIN_FLAGS_PG1];
          nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_PG0] = st.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_PG0] & wd[WKC_TIMER_RUN_AND_PIN_FLAGS_PG0];
        end
        WKC_IDX_EXTENDED_IRQ_FLAGS: nx.i2cm_flag = st.i2cm_flag & wd[WKC_EXTENDED_IRQ_FLAGS_I2CM];
        WKC_IDX_WAKE_SOURCE_MASK: nx.wake_source_mask = wd;
        WKC_IDX_IE: nx.ie = wd;
        WKC_IDX_IP: nx.ip = {1'b0, wd[6:0]};
        WKC_IDX_IRQ_ENABLE_EXTENDED: nx.irq_enable_extended = wd;
        WKC_IDX_IRQ_PRIORITY_EXTENDED: nx.irq_priority_extended = wd;
        default: nx.ie = st.ie;
      endcase
    end

    // Read data, latched with the acknowledge
    nx.rdat = st.rdat;
    if (bus_go) begin
      case (bidx)
        WKC_IDX_TIMER_RUN_AND_PIN_FLAGS: nx.rdat = {st.timer_run_and_pin_flags[7:4], st.timer_run_and_pin_flags[3], 1'b0, st.timer_run_and_pin_flags[1], 1'b0};
        WKC_IDX_EXTENDED_IRQ_FLAGS: nx.rdat = {src_i.ext_flags[5:3], 1'b0, src_i.ext_flags[2:0],
                                 st.i2cm_flag};
        WKC_IDX_WAKE_SOURCE_MASK: nx.rdat = st.wake_source_mask;
        WKC_IDX_IE: nx.rdat = st.ie;
        WKC_IDX_IP: nx.rdat = st.ip;
        WKC_IDX_IRQ_ENABLE_EXTENDED: nx.rdat = st.irq_enable_extended;
        WKC_IDX_IRQ_PRIORITY_EXTENDED: nx.rdat = st.irq_priority_extended;
        default: nx.rdat = 8'h00;
      endcase
    end

    // Vectoring clears hardware-cleared flags and pending debug events
    if (irq_ack_i && st.irq_req) begin
      if (st.sel_lvl == WKC_LVL_DBG) begin
        nx.dbg_pend = 1'b0;
      end else if (st.sel_lvl == WKC_LVL_BKP) begin
        nx.bkp_pend = 1'b0;
      end else if (st.sel_slot == WKC_SLOT_TF0) begin
        nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TF0] = 1'b0;
      end else if (st.sel_slot == WKC_SLOT_TF1) begin
        nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TF1] = 1'b0;
      end
    end

    // Hardware sets win over any clear in the same cycle
    if (src_i.timer0_ovf) begin
      nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TF0] = 1'b1;
    end
    if (src_i.timer1_ovf) begin
      nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TF1] = 1'b1;
    end
    if (grp_evt[0]) begin
      nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_PG0] = 1'b1;
    end
    if (grp_evt[1]) begin
      nx.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_PG1] = 1'b1;
    end
    if (src_i.i2cm_evt) begin
      nx.i2cm_flag = 1'b1;
    end
    if (dbg_hit) begin
      nx.dbg_pend = 1'b1;
    end
    if (bkp_match_i) begin
      nx.bkp_pend = 1'b1;
    end

    // In-service levels: return pops the highest, vectoring pushes one
    if (reti_i) begin
      if (st.svc[3]) begin
        nx.svc[3] = 1'b0;
      end else if (st.svc[2]) begin
        nx.svc[2] = 1'b0;
      end else if (st.svc[1]) begin
        nx.svc[1] = 1'b0;
      end else begin
        nx.svc[0] = 1'b0;
      end
    end
    if (irq_ack_i && st.irq_req) begin
      nx.svc[st.sel_lvl] = 1'b1;
    end

    // Arbitration, sampled every edge, withdrawn while being taken
    nx.irq_req = 1'b0;
    if (!(irq_ack_i && st.irq_req)) begin
      if (st.dbg_pend && !st.svc[3]) begin
        nx.irq_req = 1'b1;
        nx.sel_lvl = WKC_LVL_DBG;
        nx.irq_vec = {vector_relocate_select_i ? WKC_PAGE_NIBBLE : 4'h0, WKC_VEC_DBG};
      end else if (st.bkp_pend && st.svc[3:2] == 2'h0) begin
        nx.irq_req = 1'b1;
        nx.sel_lvl = WKC_LVL_BKP;
        nx.irq_vec = {vector_relocate_select_i ? WKC_PAGE_NIBBLE : 4'h0, WKC_VEC_BKP};
      end else if (hi_pick[4] && st.svc[3:1] == 3'h0) begin
        nx.irq_req = 1'b1;
        nx.sel_lvl = WKC_LVL_HI;
        nx.sel_slot = hi_pick[3:0];
        nx.irq_vec = slot_vec(vector_relocate_select_i, hi_pick[3:0]);
      end else if (lo_pick[4] && st.svc == 4'h0) begin
        nx.irq_req = 1'b1;
        nx.sel_lvl = WKC_LVL_LO;
        nx.sel_slot = lo_pick[3:0];
        nx.irq_vec = slot_vec(vector_relocate_select_i, lo_pick[3:0]);
      end
    end

    // Wake sequencer
    case (st.wstate)
      WKC_W_RUN: begin
        nx.osc_restart = 1'b0;
        if (low_power_i) begin
          nx.wstate = WKC_W_ASLEEP;
        end
      end
      WKC_W_ASLEEP: begin
        if (!low_power_i) begin
          nx.wstate = WKC_W_RUN;
        end else if (|wake_hit) begin
          nx.wstate = WKC_W_WAKING;
          nx.osc_restart = 1'b1;
        end
      end
      WKC_W_WAKING: begin
        if (!low_power_i) begin
          nx.wstate = WKC_W_RUN;
          nx.osc_restart = 1'b0;
        end
      end
      default: begin
        nx.wstate = WKC_W_RUN;
        nx.osc_restart = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= WKC_ST_RESET;
    end else begin
      st <= nx;
    end
  end

  // Outputs from the state register
  assign wb_ack_o = st.bus_ack;
  assign wb_dat_o = {24'h000000, st.rdat};
  assign irq_req_o = st.irq_req;
  assign irq_vector_o = st.irq_vec;
  assign osc_restart_o = st.osc_restart;
  assign timer0_run_o = st.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TR0];
  assign timer1_run_o = st.timer_run_and_pin_flags[WKC_TIMER_RUN_AND_PIN_FLAGS_TR1];

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Relocated vector page
  reloc_page_a: assert property (irq_req_o && $past(vector_relocate_select_i)
    |-> irq_vector_o[15:12] == 4'h7)
    else $error("relocated vector outside top page");

  // Debug request wins within one cycle
  dbg_first_a: assert property (st.dbg_pend && !st.svc[3] && !irq_ack_i
    |=> irq_req_o && irq_vector_o[11:0] == 12'h0C0)
    else $error("debug request not vectored first");

  // Debug raised on matching ID and then requested
  dbg_match_a: assert property (dbg_hit && st.svc == 4'h0 && !irq_ack_i
    ##1 !irq_ack_i |=> irq_req_o && irq_vector_o[11:0] == 12'h0C0)
    else $error("matching debug request lost");

  // Breakpoint ignores the global enable
  bkp_noen_a: assert property (bkp_match_i && !st.ie[7] && !st.dbg_pend && !dbg_hit
    && st.svc == 4'h0 && !irq_ack_i ##1 !irq_ack_i |=> irq_req_o && irq_vector_o[11:0] == 12'h080)
    else $error("breakpoint gated by enables");

  // Peripheral requests need the global enable
  global_gate_a: assert property (irq_req_o && irq_vector_o[11:0] < 12'h080
    |-> $past(st.ie[7]))
    else $error("peripheral vectored while globally disabled");

  // I2C master flag stays until cleared
  i2cm_sticky_a: assert property (src_i.i2cm_evt ##1 !bus_wr [*2]
    |-> st.i2cm_flag)
    else $error("i2c master flag not sticky");

  // Timer overflow flag cleared by vectoring
  tf0_clear_a: assert property (irq_ack_i && st.irq_req && st.sel_slot == 4'h2
    && st.sel_lvl[1] == 1'b0 && !src_i.timer0_ovf |=> !st.timer_run_and_pin_flags[5])
    else $error("timer 0 flag survived vectoring");

  // A write never sets the pin group 0 flag
  wr_noset_a: assert property (bus_wr && bidx == 8'h88 && !st.timer_run_and_pin_flags[1] && !grp_evt[0]
    |=> !st.timer_run_and_pin_flags[1])
    else $error("software write set a pin flag");

  // High-level service blocks peripheral requests
  hi_block_a: assert property (st.svc[1] && !st.dbg_pend && !st.bkp_pend && !reti_i
    |=> !irq_req_o)
    else $error("high-level service preempted");

  // Masked wake edge restarts the oscillator
  wake_edge_a: assert property (st.wstate == WKC_W_ASLEEP && low_power_i && |wake_hit
    |=> (osc_restart_o && !low_power_i) or osc_restart_o [*2])
    else $error("wake edge did not restart oscillator");

  // Bus answers one cycle after the request
  bus_ack_a: assert property (bus_go |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge timing wrong");

  // Main scenarios
  dbg_taken_c: cover property (irq_req_o && irq_ack_i && st.sel_lvl == WKC_LVL_DBG);
  nest_c: cover property (st.svc[0] && irq_ack_i && irq_req_o && st.sel_lvl == WKC_LVL_HI);
  wake_c: cover property (st.wstate == WKC_W_WAKING && !low_power_i);
  reloc_c: cover property (irq_req_o && irq_vector_o[15:12] == 4'h7);

endmodule // wkc_irq_wake

`default_nettype wire

// ---- wkc_pkg.sv ----
package wkc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] WKC_IDX_TIMER_RUN_AND_PIN_FLAGS = 8'h88;
  localparam logic [7:0] WKC_IDX_EXTENDED_IRQ_FLAGS = 8'h91;
  localparam logic [7:0] WKC_IDX_WAKE_SOURCE_MASK = 8'h9F;
  localparam logic [7:0] WKC_IDX_IE = 8'hA8;
  localparam logic [7:0] WKC_IDX_IP = 8'hB8;
  localparam logic [7:0] WKC_IDX_IRQ_ENABLE_EXTENDED = 8'hE8;
  localparam logic [7:0] WKC_IDX_IRQ_PRIORITY_EXTENDED = 8'hF8;

  // Reset values
  localparam logic [7:0] WKC_RST_ZERO = 8'h00;
  localparam logic [7:0] WKC_RST_WAKE_SOURCE_MASK = 8'hFF;

  // Field positions
  localparam int WKC_TIMER_RUN_AND_PIN_FLAGS_TF1 = 7;
  localparam int WKC_TIMER_RUN_AND_PIN_FLAGS_TR1 = 6;
  localparam int WKC_TIMER_RUN_AND_PIN_FLAGS_TF0 = 5;
  localparam int WKC_TIMER_RUN_AND_PIN_FLAGS_TR0 = 4;
  localparam int WKC_TIMER_RUN_AND_PIN_FLAGS_PG1 = 3;
  localparam int WKC_TIMER_RUN_AND_PIN_FLAGS_PG0 = 1;
  localparam int WKC_IE_GLOBAL = 7;
  localparam int WKC_EXTENDED_IRQ_FLAGS_I2CM = 0;

  // Vector layout
  localparam logic [11:0] WKC_VEC_ECC = 12'h07B;
  localparam logic [11:0] WKC_VEC_BKP = 12'h080;
  localparam logic [11:0] WKC_VEC_DBG = 12'h0C0;
  localparam logic [2:0] WKC_VEC_LOW3 = 3'h3;
  localparam logic [3:0] WKC_PAGE_NIBBLE = 4'h7;
  localparam logic [3:0] WKC_SLOT_TF0 = 4'h2;
  localparam logic [3:0] WKC_SLOT_TF1 = 4'h4;

  // Service levels
  localparam logic [1:0] WKC_LVL_LO = 2'h0;
  localparam logic [1:0] WKC_LVL_HI = 2'h1;
  localparam logic [1:0] WKC_LVL_BKP = 2'h2;
  localparam logic [1:0] WKC_LVL_DBG = 2'h3;

  // Sizes
  localparam int WKC_GPIO_N = 8;
  localparam int WKC_DBG_ID_W = 8;
  localparam int WKC_ADR_W = 10;

  // Wake sequencer states
  typedef enum logic [2:0] {
    WKC_W_RUN = 3'b001,
    WKC_W_ASLEEP = 3'b010,
    WKC_W_WAKING = 3'b100
  } wkc_wake_e;

  // Wishbone request from the bus master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WKC_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wkc_wb_req_t;

  // Peripheral request and flag lines
  typedef struct packed {
    logic timer0_ovf;
    logic timer1_ovf;
    logic uart0;
    logic timer2;
    logic uart2;
    logic i2cm_evt;
    logic watchdog;
    logic [5:0] ext_flags;
    logic ecc;
  } wkc_src_t;

  // Complete block state
  typedef struct packed {
    logic [7:0] timer_run_and_pin_flags;
    logic i2cm_flag;
    logic [7:0] wake_source_mask;
    logic [7:0] ie;
    logic [7:0] ip;
    logic [7:0] irq_enable_extended;
    logic [7:0] irq_priority_extended;
    logic dbg_pend;
    logic bkp_pend;
    logic [3:0] svc;
    logic [1:0] sel_lvl;
    logic [3:0] sel_slot;
    logic irq_req;
    logic [15:0] irq_vec;
    logic bus_ack;
    logic [7:0] rdat;
    logic [WKC_GPIO_N-1:0] gpio_s1;
    logic [WKC_GPIO_N-1:0] gpio_s2;
    logic [WKC_GPIO_N-1:0] gpio_prev;
    logic [5:0] ext_prev;
    wkc_wake_e wstate;
    logic osc_restart;
  } wkc_state_t;

  localparam wkc_state_t WKC_ST_RESET = '{
    timer_run_and_pin_flags: WKC_RST_ZERO, i2cm_flag: 1'b0, wake_source_mask: WKC_RST_WAKE_SOURCE_MASK,
    ie: WKC_RST_ZERO, ip: WKC_RST_ZERO, irq_enable_extended: WKC_RST_ZERO, irq_priority_extended: WKC_RST_ZERO,
    dbg_pend: 1'b0, bkp_pend: 1'b0, svc: 4'h0, sel_lvl: 2'h0, sel_slot: 4'h0,
    irq_req: 1'b0, irq_vec: 16'h0000, bus_ack: 1'b0, rdat: 8'h00,
    gpio_s1: '0, gpio_s2: '0, gpio_prev: '0, ext_prev: 6'h00,
    wstate: WKC_W_RUN, osc_restart: 1'b0};

endpackage
